//--- rtl/ext_mem_defines.vh
// Constants for the external memory port: fields, reset values, timing
`ifndef EXT_MEM_DEFINES_VH
`define EXT_MEM_DEFINES_VH
// Interface configuration register fields
`define CFG_MUX_BIT 4
`define CFG_MODE_HI 3
`define CFG_MODE_LO 2
`define CFG_ALE_HI 1
`define CFG_ALE_LO 0
`define CFG_RESET 8'h03
// Interface timing register fields
`define TC_SETUP_HI 7
`define TC_SETUP_LO 6
`define TC_STROBE_HI 5
`define TC_STROBE_LO 2
`define TC_HOLD_HI 1
`define TC_HOLD_LO 0
`define TC_RESET 8'hFF
// Memory modes
`define MODE_INTERNAL 2'b00
`define MODE_SPLIT_NOBANK 2'b01
`define MODE_SPLIT_BANK 2'b10
`define MODE_EXTERNAL 2'b11
// Fixed overhead cycles of an off-chip move
`define MOVE_OVERHEAD 4'h4
// Internal RAM size in bytes (wrap boundary)
`define RAM_BYTES 16'h2000
`endif

//--- rtl/phase_counter.v
// Down counter that times one phase of an off-chip access
`timescale 1ns/1ps
`default_nettype none
module phase_counter #(
   parameter WIDTH = 5
) (
   input wire mclk,
   input wire rst_b,
   input wire load,
   input wire [WIDTH-1:0] load_value,
   output wire done
);
   reg [WIDTH-1:0] count; // Cycles left in this phase

   // Load starts a phase; count runs to zero and stays there
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count <= {WIDTH{1'b0}};
      end else if (load) begin
         count <= load_value;
      end else if (count != {WIDTH{1'b0}}) begin
         count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   // Done is high in the last cycle of the phase
   assign done = (count == {WIDTH{1'b0}}) ||
                 (count == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // phase_counter
`default_nettype wire

//--- rtl/external_memory_interface.v
// External data memory port: address routing and strobe sequencing
`timescale 1ns/1ps
`default_nettype none
`include "ext_mem_defines.vh"

module external_memory_interface #(
   parameter [15:0] RAM_SIZE = `RAM_BYTES
) (
   input wire mclk,
   input wire rst_b,
   // Configuration writes from the core
   input wire cfg_write,
   input wire [7:0] cfg_wdata,
   input wire page_write,
   input wire [7:0] page_wdata,
   input wire timing_write,
   input wire [7:0] timing_wdata,
   output reg [7:0] interface_config_reg,
   output reg [7:0] page_select_reg,
   output reg [7:0] interface_timing_reg,
   // Move request from the core
   input wire move_req,
   input wire move_write,
   input wire move_wide,
   input wire [15:0] data_pointer,
   input wire [7:0] index_value,
   input wire [7:0] move_wdata,
   output wire move_busy,
   output reg move_done,
   output reg [7:0] move_rdata,
   // On-chip RAM port
   output reg ram_en,
   output reg ram_we,
   output reg [15:0] ram_addr,
   output reg [7:0] ram_wdata,
   input wire [7:0] ram_rdata,
   // External pins
   output reg [15:0] addr_out,
   output reg addr_hi_oe,
   output reg addr_lo_oe,
   output reg [7:0] data_out,
   output reg data_oe,
   input wire [7:0] data_in,
   output reg ale,
   output reg rd_n,
   output reg wr_n
);
   // One-hot sequencer states
   localparam [7:0] S_IDLE = 8'h01;
   localparam [7:0] S_ALEH = 8'h02;
   localparam [7:0] S_ALEL = 8'h04;
   localparam [7:0] S_SETUP = 8'h08;
   localparam [7:0] S_STROBE = 8'h10;
   localparam [7:0] S_HOLD = 8'h20;
   localparam [7:0] S_TAIL = 8'h40;
   localparam [7:0] S_RAM = 8'h80;

   reg [7:0] state; // Sequencer state
   reg [7:0] next_state;
   reg [7:0] din_s1; // First sync stage of data pins
   reg [7:0] din_s2; // Second sync stage, read by logic
   reg [15:0] eff_addr; // Latched effective address
   reg hi_drive; // Drive upper address lines this access
   reg is_write; // Latched direction
   reg [7:0] wdata; // Latched write data
   reg load; // Start the next phase
   reg [4:0] load_value;
   wire phase_done;

   // Decoded fields
   wire mux_mode = ~interface_config_reg[`CFG_MUX_BIT];
   wire [1:0] memory_mode_field =
      interface_config_reg[`CFG_MODE_HI:`CFG_MODE_LO];
   wire [1:0] latch_width_field =
      interface_config_reg[`CFG_ALE_HI:`CFG_ALE_LO];
   wire [1:0] addr_setup_field =
      interface_timing_reg[`TC_SETUP_HI:`TC_SETUP_LO];
   wire [3:0] strobe_width_field =
      interface_timing_reg[`TC_STROBE_HI:`TC_STROBE_LO];
   wire [1:0] addr_hold_field =
      interface_timing_reg[`TC_HOLD_HI:`TC_HOLD_LO];

   // Request-time address and routing
   reg [15:0] req_addr;
   reg req_offchip;
   reg req_hi_drive;
   wire [15:0] ram_size16 = RAM_SIZE;

   // Phase length in cycles: a field code plus one
   function [4:0] widen;
      input [3:0] code;
      begin
         widen = {1'b0, code} + 5'h01;
      end
   endfunction

   // Resolve effective address and destination of a new move
   always @* begin
      req_addr = move_wide ? data_pointer
                           : {page_select_reg, index_value};
      req_offchip = 1'b0;
      req_hi_drive = 1'b1;
      case (memory_mode_field)
         `MODE_INTERNAL: req_offchip = 1'b0;
         `MODE_SPLIT_NOBANK: begin
            req_offchip = (req_addr >= ram_size16);
            req_hi_drive = move_wide;
         end
         `MODE_SPLIT_BANK: req_offchip = (req_addr >= ram_size16);
         `MODE_EXTERNAL: begin
            req_offchip = 1'b1;
            req_hi_drive = move_wide;
            if (!move_wide) begin
               req_addr = {8'h00, index_value};
            end
         end
         default: req_offchip = 1'b0;
      endcase
   end

   // Configuration registers; setup and hold reset to maximum
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         interface_config_reg <= `CFG_RESET;
         page_select_reg <= 8'h00;
         interface_timing_reg <= `TC_RESET;
      end else begin
         if (cfg_write) interface_config_reg <= cfg_wdata;
         if (page_write) page_select_reg <= page_wdata;
         if (timing_write) interface_timing_reg <= timing_wdata;
      end
   end

   // Data pins come from outside, so two flops first
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         din_s1 <= 8'h00;
         din_s2 <= 8'h00;
      end else begin
         din_s1 <= data_in;
         din_s2 <= din_s1;
      end
   end

   // Next state and phase loads; each phase lasts its count
   always @* begin
      next_state = state;
      load = 1'b0;
      load_value = 5'h00;
      case (state)
         S_IDLE: begin
            if (move_req) begin
               load = 1'b1;
               if (!req_offchip) begin
                  next_state = S_RAM;
                  load_value = 5'h01;
               end else if (mux_mode) begin
                  next_state = S_ALEH;
                  load_value = widen({2'b00, latch_width_field});
               end else begin
                  next_state = S_SETUP;
                  load_value = widen({2'b00, addr_setup_field});
               end
            end
         end
         S_ALEH: begin
            if (phase_done) begin
               next_state = S_ALEL;
               load = 1'b1;
               load_value = widen({2'b00, latch_width_field});
            end
         end
         S_ALEL: begin
            if (phase_done) begin
               next_state = S_SETUP;
               load = 1'b1;
               load_value = widen({2'b00, addr_setup_field});
            end
         end
         S_SETUP: begin
            // One setup cycle is part of the fixed overhead
            if (phase_done) begin
               next_state = S_STROBE;
               load = 1'b1;
               load_value = widen(strobe_width_field);
            end
         end
         S_STROBE: begin
            if (phase_done) begin
               next_state = S_HOLD;
               load = 1'b1;
               load_value = widen({2'b00, addr_hold_field});
            end
         end
         S_HOLD: begin
            if (phase_done) begin
               next_state = S_TAIL;
               load = 1'b1;
               load_value = 5'h02;
            end
         end
         S_TAIL: if (phase_done) next_state = S_IDLE;
         S_RAM: next_state = S_IDLE;
         default: next_state = S_IDLE;
      endcase
   end

   phase_counter #(.WIDTH(5)) u_phase (
      .mclk(mclk),
      .rst_b(rst_b),
      .load(load),
      .load_value(load_value),
      .done(phase_done)
   );

   assign move_busy = (state != S_IDLE);
   // Sequencer registers and pin drive
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state <= S_IDLE;
         eff_addr <= 16'h0000;
         hi_drive <= 1'b0;
         is_write <= 1'b0;
         wdata <= 8'h00;
         move_done <= 1'b0;
         move_rdata <= 8'h00;
         ram_en <= 1'b0;
         ram_we <= 1'b0;
         ram_addr <= 16'h0000;
         ram_wdata <= 8'h00;
         addr_out <= 16'h0000;
         addr_hi_oe <= 1'b0;
         addr_lo_oe <= 1'b0;
         data_out <= 8'h00;
         data_oe <= 1'b0;
         ale <= 1'b0;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
      end else begin
         state <= next_state;
         move_done <= 1'b0;
         ram_en <= 1'b0;
         ram_we <= 1'b0;
         if (state == S_IDLE && move_req) begin
            eff_addr <= req_addr;
            hi_drive <= req_hi_drive;
            is_write <= move_write;
            wdata <= move_wdata;
            if (!req_offchip) begin
               // Wrap on RAM size: 0x2000, 0x4000 hit 0x0000
               ram_en <= 1'b1;
               ram_we <= move_write;
               ram_addr <= req_addr & (ram_size16 - 16'h0001);
               ram_wdata <= move_wdata;
            end
         end
         // On-chip read data is ready one cycle after the enable
         if (state == S_RAM) begin
            move_rdata <= ram_rdata;
            move_done <= 1'b1;
         end
         // Pin drive follows the next state
         case (next_state)
            // Address loads only on entry; core inputs may move later
            S_ALEH: if (state == S_IDLE) begin
               ale <= 1'b1;
               addr_out <= req_addr;
               addr_hi_oe <= req_hi_drive;
               addr_lo_oe <= 1'b0;
               data_out <= req_addr[7:0];
               data_oe <= 1'b1;
            end
            S_ALEL: begin
               ale <= 1'b0;
               data_oe <= 1'b0; // Release before data phase
            end
            S_SETUP: begin
               ale <= 1'b0;
               if (state == S_IDLE) begin
                  addr_out <= req_addr;
                  addr_hi_oe <= req_hi_drive;
                  addr_lo_oe <= 1'b1;
               end
               data_oe <= 1'b0;
            end
            S_STROBE: begin
               rd_n <= is_write;
               wr_n <= ~is_write;
               data_out <= wdata;
               data_oe <= is_write;
            end
            S_HOLD: begin
               rd_n <= 1'b1;
               wr_n <= 1'b1;
               if (state == S_STROBE && !is_write) begin
                  move_rdata <= din_s2;
               end
            end
            S_IDLE: begin
               if (state == S_TAIL) begin
                  move_done <= 1'b1;
                  addr_hi_oe <= 1'b0;
                  addr_lo_oe <= 1'b0;
                  data_oe <= 1'b0;
               end
            end
            default: ale <= ale;
         endcase
      end
   end
endmodule // external_memory_interface
`default_nettype wire

//--- sim/emi_props.sv
// Pin-level checker for the external memory port
`timescale 1ns/1ps
`default_nettype none
module emi_props (
   input wire mclk,
   input wire rst_b,
   input wire [7:0] interface_config_reg,
   input wire [7:0] interface_timing_reg,
   input wire ale,
   input wire rd_n,
   input wire wr_n,
   input wire data_oe,
   input wire [7:0] data_out,
   input wire [15:0] addr_out,
   input wire ram_en,
   input wire move_busy,
   input wire addr_lo_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   reg [4:0] low_cnt; // Cycles a strobe has been low
   reg [4:0] ale_cnt; // Cycles the latch strobe has been high
   wire [1:0] mode = interface_config_reg[3:2];
   // Width counters; the timing fields must not change mid-access
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         low_cnt <= 5'h0;
         ale_cnt <= 5'h0;
      end else begin
         low_cnt <= (rd_n && wr_n) ? 5'h0 : low_cnt + 5'h1;
         ale_cnt <= ale ? ale_cnt + 5'h1 : 5'h0;
      end
   end
   sequence latch_end;
      ale ##1 !ale;
   endsequence
   a_nonmux_no_latch: assert property (
      interface_config_reg[4] |-> !ale)
      else $error("latch strobe in separate-pin mode");
   a_latch_low_addr: assert property (
      ale |-> data_oe && data_out == addr_out[7:0])
      else $error("low address missing while latch open");
   a_write_drives_data: assert property (!wr_n |-> data_oe)
      else $error("write strobe without data drive");
   a_internal_no_pins: assert property (
      mode == 2'b00 |-> rd_n && wr_n && !ale)
      else $error("pin activity in internal mode");
   a_external_no_ram: assert property (mode == 2'b11 |-> !ram_en)
      else $error("on-chip access in external mode");
   a_strobe_width_ok: assert property (
      $rose(rd_n && wr_n) |->
      low_cnt == {1'b0, interface_timing_reg[5:2]} + 5'h1)
      else $error("strobe width wrong");
   a_latch_width_ok: assert property (
      $fell(ale) |->
      ale_cnt == {3'b000, interface_config_reg[1:0]} + 5'h1)
      else $error("latch high width wrong");
   a_latch_then_idle: assert property (latch_end |-> rd_n && wr_n)
      else $error("strobe at latch fall");
   a_reset_max_delay: assert property (
      $rose(rst_b) |-> interface_timing_reg == 8'hFF)
      else $error("timing not at maximum after reset");
   // Pins only move inside an access the core sees as busy
   a_pins_need_busy: assert property (
      (!rd_n || !wr_n || ale) |-> move_busy)
      else $error("pin strobe outside an access");
   a_sep_low_drive: assert property (
      interface_config_reg[4] && !(rd_n && wr_n) |-> addr_lo_oe)
      else $error("low address lines idle during strobe");
   a_mux_low_shared: assert property (
      !interface_config_reg[4] |-> !addr_lo_oe)
      else $error("separate low address lines in shared mode");
endmodule // emi_props
`default_nettype wire

//--- sim/ext_sram_model.sv
// Off-chip SRAM with its low address latch
`timescale 1ns/1ps
`default_nettype none
module ext_sram_model (
   input wire sep_pins,
   input wire [15:0] addr_out,
   input wire addr_hi_oe,
   input wire [7:0] data_out,
   input wire data_oe,
   input wire ale,
   input wire rd_n,
   input wire wr_n,
   output logic [7:0] data_in
);
   logic [7:0] mem [0:65535]; // Storage
   logic [7:0] low_latch; // Latched low address
   // Released upper lines float to the pull-up level
   wire [7:0] hi = addr_hi_oe ? addr_out[15:8] : 8'hFF;
   wire [7:0] lo = sep_pins ? addr_out[7:0] : low_latch;
   // Transparent while open, frozen once the strobe falls
   always_latch if (ale) low_latch = data_out;
   // Store while the write strobe is low
   always @* if (!wr_n && data_oe) mem[{hi, lo}] = data_out;
   // Off a read, show the inverse so stale data never looks right
   assign data_in = rd_n ? ~mem[{hi, lo}] : mem[{hi, lo}];
endmodule // ext_sram_model
`default_nettype wire

//--- sim/external_memory_interface_test.sv
// Self-checking bench for the external memory port
`timescale 1ns/1ps
`default_nettype none
module external_memory_interface_test;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic cfg_write = 1'b0, page_write = 1'b0, timing_write = 1'b0;
   logic [7:0] cfg_wdata = 8'h00, page_wdata = 8'h00, timing_wdata = 8'h00;
   logic move_req = 1'b0, move_write = 1'b0, move_wide = 1'b0;
   logic [15:0] data_pointer = 16'h0000;
   logic [7:0] index_value = 8'h00, move_wdata = 8'h00;
   wire [7:0] interface_config_reg, page_select_reg, interface_timing_reg;
   wire move_busy, move_done, ram_en, ram_we, addr_hi_oe, addr_lo_oe;
   wire [7:0] move_rdata, ram_wdata, ram_rdata, data_out, data_in;
   wire [15:0] ram_addr, addr_out;
   wire data_oe, ale, rd_n, wr_n;
   int bad_count = 0, total_checks = 0;
   logic [31:0] seed = 32'h0000_4a04; // Random source state
   logic [7:0] cur_cfg, cur_tim, cur_pg; // Bench copy of the settings
   logic [7:0] ram [0:65535]; // On-chip RAM behind the port
   logic [7:0] bram [int]; // Expected on-chip contents
   logic [7:0] eram [int]; // Expected off-chip contents
   external_memory_interface DUT (.mclk(mclk), .rst_b(rst_b),
      .cfg_write(cfg_write), .cfg_wdata(cfg_wdata),
      .page_write(page_write), .page_wdata(page_wdata),
      .timing_write(timing_write), .timing_wdata(timing_wdata),
      .interface_config_reg(interface_config_reg),
      .page_select_reg(page_select_reg),
      .interface_timing_reg(interface_timing_reg),
      .move_req(move_req), .move_write(move_write), .move_wide(move_wide),
      .data_pointer(data_pointer), .index_value(index_value),
      .move_wdata(move_wdata), .move_busy(move_busy),
      .move_done(move_done), .move_rdata(move_rdata), .ram_en(ram_en),
      .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
      .ram_rdata(ram_rdata), .addr_out(addr_out), .addr_hi_oe(addr_hi_oe),
      .addr_lo_oe(addr_lo_oe), .data_out(data_out), .data_oe(data_oe),
      .data_in(data_in), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
   ext_sram_model far (.sep_pins(interface_config_reg[4]),
      .addr_out(addr_out), .addr_hi_oe(addr_hi_oe), .data_out(data_out),
      .data_oe(data_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
      .data_in(data_in));
   initial forever #25 mclk = ~mclk;
   // RAM reads are combinational, so data is ready the cycle after
   assign ram_rdata = ram[ram_addr];
   always @(posedge mclk) if (ram_en && ram_we) ram[ram_addr] <= ram_wdata;
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task check(input string what, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task finish_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // All three registers are written in one strobe cycle
   task setcfg(input logic [7:0] c, t, p);
      @(posedge mclk);
      {cfg_write, page_write, timing_write} <= 3'b111;
      {cfg_wdata, timing_wdata, page_wdata} <= {c, t, p};
      @(posedge mclk);
      {cfg_write, page_write, timing_write} <= 3'b000;
      {cur_cfg, cur_tim, cur_pg} = {c, t, p};
   endtask
   // One move; the model decides route, lines and duration
   task mv(input logic w, wide, input logic [15:0] dp, input logic [7:0] ix);
      logic [15:0] ea, xa, key;
      logic off, hi, s_off, s_hi;
      logic [7:0] wd;
      int n, en;
      wd = 8'(rnd());
      ea = wide ? dp : {cur_pg, ix};
      off = cur_cfg[3:2] == 2'b11 ||
         (cur_cfg[3:2] != 2'b00 && ea >= 16'h2000);
      hi = wide || cur_cfg[3:2] == 2'b10;
      xa = hi ? ea : {8'hFF, ix};
      key = {3'b000, ea[12:0]};
      en = cur_tim[7:6] + cur_tim[5:2] + 1 + cur_tim[1:0] + 4;
      if (!cur_cfg[4]) en = en + 2 * (cur_cfg[1:0] + 1);
      // On-chip result is registered one edge after the take
      if (!off) en = 1;
      @(posedge mclk);
      move_req <= 1'b1;
      {move_write, move_wide, data_pointer} <= {w, wide, dp};
      {index_value, move_wdata} <= {ix, wd};
      @(posedge mclk);
      move_req <= 1'b0;
      {s_off, s_hi, n} = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
         s_off = s_off | !rd_n | !wr_n;
         s_hi = s_hi | addr_hi_oe;
      end while (move_done !== 1'b1 && n < 300);
      check("done", 16'(move_done), 16'h0001);
      if (move_done !== 1'b1) finish_test();
      check("route", 16'(s_off), 16'(off));
      if (off) check("upper drive", 16'(s_hi), 16'(hi));
      check("length", 16'(n), 16'(en));
      if (w && off) eram[xa] = wd;
      if (w && !off) bram[key] = wd;
      if (!w) wd = off ? eram[xa] : bram[key];
      if (!w) check("read", 16'(move_rdata), 16'(wd));
   endtask
   initial begin
      logic [31:0] r;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      #1;
      check("config", 16'(interface_config_reg), 16'h0003);
      check("timing", 16'(interface_timing_reg), 16'h00FF);
      check("page", 16'(page_select_reg), 16'h0000);
      {cur_cfg, cur_tim, cur_pg} = {8'h03, 8'hFF, 8'h00};
      mv(1'b1, 1'b1, 16'h2000, 8'h00);
      mv(1'b0, 1'b1, 16'h0000, 8'h00);
      mv(1'b0, 1'b1, 16'h4000, 8'h00);
      // Every mode in both bus forms; fastest timing write-only
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         setcfg({3'b000, i[2], i[1:0], r[1:0]},
            i < 8 ? 8'h00 : r[15:8] | 8'h08, r[23:16]);
         mv(1'b1, 1'b0, 16'h0000, r[31:24]);
         if (i >= 8) mv(1'b0, 1'b0, 16'h0000, r[31:24]);
         mv(1'b1, 1'b1, r[15:0] ^ r[31:16], 8'h00);
         if (i >= 8) mv(1'b0, 1'b1, r[15:0] ^ r[31:16], 8'h00);
      end
      finish_test();
   end
endmodule // external_memory_interface_test
bind external_memory_interface emi_props chk (.mclk(mclk), .rst_b(rst_b),
   .interface_config_reg(interface_config_reg),
   .interface_timing_reg(interface_timing_reg), .ale(ale), .rd_n(rd_n),
   .wr_n(wr_n), .data_oe(data_oe), .data_out(data_out),
   .addr_out(addr_out), .ram_en(ram_en), .move_busy(move_busy),
   .addr_lo_oe(addr_lo_oe));
`default_nettype wire
